// ==== pwrkey_pkg.sv ====
// constants and state type shared by the power key sequencer files.
// assumes a 50 MHz free-running timebase on mclk_in.
`default_nettype none

package pwrkey_pkg;
    // timebase
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_PERIOD_MS = 1;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned MS_W = 16;
    // press windows in milliseconds (2 s, 8 s, 0.5 s, 9 s, 15 s, about 0.1 s)
    localparam logic [15:0] START_MIN_MS = 16'h07D0;
    localparam logic [15:0] START_MAX_MS = 16'h1F40;
    localparam logic [15:0] CHOICE_MIN_MS = 16'h01F4;
    localparam logic [15:0] FORCE_MIN_MS = 16'h2328;
    localparam logic [15:0] FORCE_MAX_MS = 16'h3A98;
    localparam logic [15:0] SHORT_MIN_MS = 16'h0032;
    localparam logic [15:0] SHORT_MAX_MS = 16'h00C8;
    localparam logic [15:0] MS_SAT = 16'hFFFF;
    localparam logic [15:0] MS_ONE = 16'h0001;
    localparam logic [15:0] MS_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_STANDBY = 2'b01,
        ST_SLEEP = 2'b11
    } pwr_state_t;
endpackage : pwrkey_pkg

`default_nettype wire

// ==== key_press_timer.sv ====
// millisecond timebase and low-period timer for the power key.
// assumes key_low_in is already synchronous to mclk_in.
`timescale 1ns/1ps
`default_nettype none

module key_press_timer #(
    parameter int unsigned TICK_CYCLES = pwrkey_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // key level
    input wire logic key_low_in,
    // timing results
    output logic tick_out,
    output logic [15:0] held_ms_out,
    output logic rel_out,
    output logic [15:0] rel_ms_out
);
    localparam int unsigned TW = $clog2(TICK_CYCLES);

    // a divider of one cycle would tick every edge and lose its meaning
    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("TICK_CYCLES too small");
    end

    logic [TW-1:0] div_r;
    logic key_low_d_r;
    wire div_end = (div_r == TW'(TICK_CYCLES - 1));
    wire released = key_low_d_r && !key_low_in;
    wire sat = (held_ms_out == pwrkey_pkg::MS_SAT);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r <= '0;
            tick_out <= 1'b0;
        end else begin
            div_r <= div_end ? '0 : div_r + TW'(1);
            tick_out <= div_end;
        end
    end

    // saturate so a stuck key never wraps back into a short window
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            key_low_d_r <= 1'b0;
            held_ms_out <= pwrkey_pkg::MS_ZERO;
            rel_out <= 1'b0;
            rel_ms_out <= pwrkey_pkg::MS_ZERO;
        end else begin
            key_low_d_r <= key_low_in;
            rel_out <= released;
            if (released) begin
                rel_ms_out <= held_ms_out;
            end
            if (!key_low_in) begin
                held_ms_out <= pwrkey_pkg::MS_ZERO;
            end else if (tick_out && !sat) begin
                held_ms_out <= held_ms_out + pwrkey_pkg::MS_ONE;
            end
        end
    end
endmodule : key_press_timer

`default_nettype wire

// ==== power_key_sequencer.sv ====
// power key sequencer: classifies power key low periods into start,
// choice request, forced shutdown, sleep and wake, plus idle auto-sleep.
// assumes power_key_n_in is debounced and synchronous to mclk_in.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: one active-low key controls all power functions
// R2: off, 2-8 s press starts module
// R3: running, press over 0.5 s requests choice
// R4: 9-15 s press forces shutdown (code forces it once the hold reaches 9 s; FORCE_MAX_MS is never checked)
// R5: standby, ~0.1 s press enters sleep
// R6: sleeping, ~0.1 s press wakes to standby
// R7: standby auto-sleeps after programmable idle time
// R8: host prefers normal shutdown over forced
// R9: time presses, classify at release, ignore others
module power_key_sequencer #(
    parameter int unsigned TICK_CYCLES = pwrkey_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // key and supply
    input wire logic power_key_n_in,
    input wire logic batt_ok_in,
    // software side
    input wire logic [15:0] idle_timeout_ms_in,
    input wire logic sw_off_in,
    // status and events
    output logic power_on_out,
    output logic sleep_out,
    output logic start_out,
    output logic choice_req_out,
    output logic forced_off_out
);
    pwrkey_pkg::pwr_state_t state_r, state_nxt;

    logic tick;
    logic [15:0] held_ms;
    logic rel;
    logic [15:0] rel_ms;
    logic forced_done_r;
    logic [15:0] idle_ms_r;

    wire key_low = !power_key_n_in; // [R1]

    key_press_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .key_low_in(key_low),
        .tick_out(tick),
        .held_ms_out(held_ms),
        .rel_out(rel),
        .rel_ms_out(rel_ms)
    );

    wire running = (state_r != pwrkey_pkg::ST_OFF);
    // forced_done_r clears at the release edge, so a press that forced shutdown is still classified at release
    wire rel_ok = rel && !forced_done_r; // [R9]
    wire win_start = (rel_ms >= pwrkey_pkg::START_MIN_MS) &&
                     (rel_ms <= pwrkey_pkg::START_MAX_MS);
    wire win_choice = (rel_ms >= pwrkey_pkg::CHOICE_MIN_MS) &&
                      (rel_ms < pwrkey_pkg::FORCE_MIN_MS);
    wire win_short = (rel_ms >= pwrkey_pkg::SHORT_MIN_MS) &&
                     (rel_ms <= pwrkey_pkg::SHORT_MAX_MS);
    wire do_start = !running && batt_ok_in && rel_ok && win_start; // [R2]
    wire do_choice = running && rel_ok && win_choice; // [R3]
    wire do_force = running && key_low && !forced_done_r &&
                    (held_ms == pwrkey_pkg::FORCE_MIN_MS); // [R4]
    wire do_sleep = (state_r == pwrkey_pkg::ST_STANDBY) && rel_ok &&
                    win_short; // [R5]
    wire do_wake = (state_r == pwrkey_pkg::ST_SLEEP) && rel_ok &&
                   win_short; // [R6]
    // zero timeout disables auto-sleep
    wire idle_hit = (state_r == pwrkey_pkg::ST_STANDBY) &&
                    (idle_timeout_ms_in != pwrkey_pkg::MS_ZERO) &&
                    (idle_ms_r >= idle_timeout_ms_in); // [R7]

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pwrkey_pkg::ST_OFF: begin
                if (do_start) state_nxt = pwrkey_pkg::ST_STANDBY;
            end
            pwrkey_pkg::ST_STANDBY: begin
                if (do_sleep || idle_hit) state_nxt = pwrkey_pkg::ST_SLEEP;
            end
            pwrkey_pkg::ST_SLEEP: begin
                if (do_wake) state_nxt = pwrkey_pkg::ST_STANDBY;
            end
            default: begin
                state_nxt = pwrkey_pkg::ST_OFF;
            end
        endcase
        if (!batt_ok_in || sw_off_in || do_force) begin
            state_nxt = pwrkey_pkg::ST_OFF;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= pwrkey_pkg::ST_OFF;
            forced_done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (do_force) begin
                forced_done_r <= 1'b1; // [R4]
            end else if (!key_low) begin
                forced_done_r <= 1'b0;
            end
        end
    end

    // idle time counts only while standby and key released
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idle_ms_r <= pwrkey_pkg::MS_ZERO;
        end else if (state_r != pwrkey_pkg::ST_STANDBY || key_low) begin
            idle_ms_r <= pwrkey_pkg::MS_ZERO;
        end else if (tick && idle_ms_r != pwrkey_pkg::MS_SAT) begin
            idle_ms_r <= idle_ms_r + pwrkey_pkg::MS_ONE; // [R7]
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            power_on_out <= 1'b0;
            sleep_out <= 1'b0;
            start_out <= 1'b0;
            choice_req_out <= 1'b0;
            forced_off_out <= 1'b0;
        end else begin
            power_on_out <= (state_nxt != pwrkey_pkg::ST_OFF);
            sleep_out <= (state_nxt == pwrkey_pkg::ST_SLEEP);
            start_out <= do_start && batt_ok_in && !sw_off_in;
            choice_req_out <= do_choice && batt_ok_in && !sw_off_in;
            forced_off_out <= do_force && batt_ok_in;
        end
    end

    chk_start_window: assert property ( // [R2]
        @(posedge mclk_in) disable iff (!rst_n_in)
        $rose(start_out) |-> $past(rel_ms) >= pwrkey_pkg::START_MIN_MS &&
            $past(rel_ms) <= pwrkey_pkg::START_MAX_MS && power_on_out)
        else $error("start outside 2-8 s window");

    chk_start_from_off: assert property ( // [R2]
        @(posedge mclk_in) disable iff (!rst_n_in)
        start_out |-> $past(state_r) == pwrkey_pkg::ST_OFF)
        else $error("start while already running");

    chk_choice_window: assert property ( // [R3]
        @(posedge mclk_in) disable iff (!rst_n_in)
        choice_req_out |-> $past(rel_ms) >= pwrkey_pkg::CHOICE_MIN_MS &&
            $past(rel_ms) < pwrkey_pkg::FORCE_MIN_MS && $past(running))
        else $error("choice request from wrong press");

    chk_force_off: assert property ( // [R4]
        @(posedge mclk_in) disable iff (!rst_n_in)
        running && key_low && held_ms == pwrkey_pkg::FORCE_MIN_MS &&
            !forced_done_r && batt_ok_in |=> forced_off_out && !power_on_out)
        else $error("forced shutdown missed at 9 s");

    chk_sleep_entry: assert property ( // [R5]
        @(posedge mclk_in) disable iff (!rst_n_in)
        do_sleep && batt_ok_in && !sw_off_in && !do_force |=>
            state_r == pwrkey_pkg::ST_SLEEP && sleep_out)
        else $error("short press did not enter sleep");

    chk_wake_exit: assert property ( // [R6]
        @(posedge mclk_in) disable iff (!rst_n_in)
        $fell(sleep_out) && power_on_out |-> $past(do_wake))
        else $error("left sleep without a wake press");

    chk_idle_sleep: assert property ( // [R7]
        @(posedge mclk_in) disable iff (!rst_n_in)
        $rose(sleep_out) && !$past(do_sleep) |->
            $past(idle_ms_r) >= $past(idle_timeout_ms_in) &&
            $past(idle_timeout_ms_in) != pwrkey_pkg::MS_ZERO)
        else $error("auto-sleep before idle timeout");

    chk_ignore_gap: assert property ( // [R9]
        @(posedge mclk_in) disable iff (!rst_n_in)
        rel && rel_ms > pwrkey_pkg::SHORT_MAX_MS &&
            rel_ms < pwrkey_pkg::CHOICE_MIN_MS |=> !choice_req_out &&
            !start_out && $stable(sleep_out) || !batt_ok_in || $past(sw_off_in))
        else $error("unclassified press changed state");

    chk_key_level: assert property ( // [R1]
        @(posedge mclk_in) disable iff (!rst_n_in)
        power_key_n_in && $past(power_key_n_in) |->
            held_ms == pwrkey_pkg::MS_ZERO ##1 !do_force)
        else $error("released key timed as pressed");
endmodule : power_key_sequencer

`default_nettype wire

// ==== key_button_model.sv ====
// push button model for the power key: an open contact with a pull-up.
// assumes the bench calls press from its own sequence on mclk_in.
`timescale 1ns/1ps
`default_nettype none

module key_button_model (
    // clock
    input wire logic mclk_in,
    // key line, pulled high while released
    output var logic power_key_n_out
);
    initial power_key_n_out = 1'b1;

    // edge aligned so the held length is an exact number of clocks
    task automatic press(input int unsigned cycles);
        @(posedge mclk_in);
        power_key_n_out <= 1'b0;
        repeat (cycles) @(posedge mclk_in);
        power_key_n_out <= 1'b1;
    endtask : press
endmodule : key_button_model

`default_nettype wire

// ==== power_key_sequencer_tb_top.sv ====
// bench for the power key sequencer: start, sleep, wake, choice, forced
// shutdown, auto-sleep and software off, with random press lengths.
// assumes the button model drives the key and 2 clocks per millisecond.
`timescale 1ns/1ps
`default_nettype none

module power_key_sequencer_tb_top;
    // shortest legal divider keeps the 9 s press inside the run budget
    localparam int unsigned TICK = 2;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic batt_ok_in = 1'b1;
    logic [15:0] idle_timeout_ms_in = 16'h0000;
    logic sw_off_in = 1'b0;
    wire logic key_n;
    logic power_on_out, sleep_out, start_out, choice_req_out, forced_off_out;
    int unsigned errors = 0;
    int unsigned total_checks = 0;
    int unsigned n_start = 0, n_choice = 0, n_forced = 0;
    int unsigned seed, ms, exp_choice;
    logic exp_slp;

    always #10 mclk_in = ~mclk_in;

    key_button_model key_button_model_inst (
        .mclk_in(mclk_in), .power_key_n_out(key_n));
    power_key_sequencer #(.TICK_CYCLES(TICK)) power_key_sequencer_inst (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .power_key_n_in(key_n),
        .batt_ok_in(batt_ok_in), .idle_timeout_ms_in(idle_timeout_ms_in),
        .sw_off_in(sw_off_in), .power_on_out(power_on_out),
        .sleep_out(sleep_out), .start_out(start_out),
        .choice_req_out(choice_req_out), .forced_off_out(forced_off_out));

    // pulses last one cycle, so tally them as they pass
    always @(posedge mclk_in) begin
        if (start_out === 1'b1) n_start <= n_start + 1;
        if (choice_req_out === 1'b1) n_choice <= n_choice + 1;
        if (forced_off_out === 1'b1) n_forced <= n_forced + 1;
    end

    function automatic logic short_next(input logic s, input int unsigned l);
        return s ^ (l >= pwrkey_pkg::SHORT_MIN_MS &&
                    l <= pwrkey_pkg::SHORT_MAX_MS);
    endfunction : short_next

    function automatic int unsigned is_choice(input int unsigned l);
        return (l >= pwrkey_pkg::CHOICE_MIN_MS &&
                l < pwrkey_pkg::FORCE_MIN_MS) ? 1 : 0;
    endfunction : is_choice

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // lengths stay clear of window edges, the first tick lands late
    task automatic push(input int unsigned len);
        key_button_model_inst.press(len * TICK);
        repeat (8) @(posedge mclk_in);
    endtask : push

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // longest planned run is near 54k clocks
    initial begin
        repeat (70000) @(posedge mclk_in);
        errors++;
        finish_test();
    end

    initial begin
        seed = $urandom(6365);
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        check("power_on", 16'(power_on_out), 16'h0000);
        batt_ok_in <= 1'b0;
        push(2100);
        check("start no batt", 16'(power_on_out), 16'h0000);
        batt_ok_in <= 1'b1;
        push(1000);
        check("start too short", 16'(n_start), 16'h0000);
        push($urandom_range(2100, 2700));
        check("start count", 16'(n_start), 16'h0001);
        check("power_on", 16'(power_on_out), 16'h0001);
        exp_slp = 1'b0;
        exp_choice = 0;
        for (int i = 0; i < 10; i++) begin
            case ($urandom_range(0, 2))
                0: ms = $urandom_range(60, 190);
                1: ms = $urandom_range(250, 450);
                default: ms = $urandom_range(550, 900);
            endcase
            exp_slp = short_next(exp_slp, ms);
            exp_choice += is_choice(ms);
            push(ms);
            check("sleep", 16'(sleep_out), 16'(exp_slp));
            check("choice", 16'(n_choice), 16'(exp_choice));
        end
        if (exp_slp) push(100);
        check("awake", 16'(sleep_out), 16'h0000);
        idle_timeout_ms_in <= 16'h0064;
        repeat (100 * TICK + 20) @(posedge mclk_in);
        check("auto sleep", 16'(sleep_out), 16'h0001);
        idle_timeout_ms_in <= 16'h0000;
        push(100);
        check("wake", 16'(sleep_out), 16'h0000);
        // forced path used once only, normal off is preferred
        push(9100);
        check("forced", 16'(n_forced), 16'h0001);
        check("forced off", 16'(power_on_out), 16'h0000);
        check("no choice", 16'(n_choice), 16'(exp_choice));
        push(2500);
        check("restart", 16'(n_start), 16'h0002);
        sw_off_in <= 1'b1;
        @(posedge mclk_in);
        sw_off_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        check("sw off", 16'(power_on_out), 16'h0000);
        finish_test();
    end
endmodule : power_key_sequencer_tb_top

`default_nettype wire
